// ### bench/ssp_peer.sv
// Remote serial device: slave to the port's clock, or master at 125 ns
`timescale 1ns/1ps
module ssp_peer (
    input  wire sck_i,
    input  wire mosi_i,
    input  wire miso_i,
    output reg  sck_o,
    output wire dout_o,
    output reg  ss_n_o
);
    reg [7:0] tx_reg;
    reg [7:0] rx_reg;
    reg       lead;
    integer   bits;
    integer   k;
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        lead = 1'b0;
        bits = 0;
        tx_reg = 8'h00;
        rx_reg = 8'h00;
    end
    // MSB first, mode 0; shifted-in filler keeps an idle line toggling
    assign dout_o = tx_reg[7];
    always @(posedge sck_i) begin
        rx_reg <= {rx_reg[6:0], lead ? miso_i : mosi_i};
        bits <= bits + 1;
    end
    always @(negedge sck_i) begin
        tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
    end
    // Master role: clock stands still outside the frame
    task send(input [7:0] b);
        begin
            lead = 1'b1;
            tx_reg = b;
            ss_n_o = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                #62.5 sck_o = 1'b1;
                #62.5 sck_o = 1'b0;
            end
            #62.5 ss_n_o = 1'b1;
            lead = 1'b0;
        end
    endtask
endmodule

// ### bench/ssp_top_chk.sv
// Port-level assertions of the serial port
`timescale 1ns/1ps
module ssp_top_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        we_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        ack_o,
    input wire        irq_o,
    input wire        int_req_o,
    input wire        sck_o,
    input wire        sck_oe_n_o,
    input wire        mosi_o,
    input wire        mosi_oe_n_o,
    input wire        miso_oe_n_o,
    input wire        ss_n_i,
    input wire        ss_gpio_free_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers and the quiet state after reset
    chk_reset_quiet: assert property (
        $fell(rst_i) |-> !ack_o && dat_o == 32'h0000_0000 && !irq_o && !int_req_o)
        else $error("outputs not quiet after reset");
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_unmapped_zero: assert property (ack_o && !we_i && adr_i > 8'h10 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    // MOSI output only in the master role, with MISO released
    chk_out_role: assert property (
        !mosi_oe_n_o |-> !sck_oe_n_o && miso_oe_n_o)
        else $error("data output driven in wrong role");
    // Select low as master must drop the port within a few cycles
    chk_fault_release: assert property (
        !sck_oe_n_o && !ss_gpio_free_o && !ss_n_i |-> ##[0:5] sck_oe_n_o)
        else $error("master fault did not release port");
    chk_sck_half: assert property (
        !sck_oe_n_o && $changed(sck_o) |=> $stable(sck_o) [*3])
        else $error("serial clock half period wrong");
    chk_mosi_hold: assert property (
        sck_o ##1 sck_o |-> $stable(mosi_o))
        else $error("data changed while clock high");
endmodule

// ### bench/test_ssp_top.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
module test_ssp_top;
    reg         clk_i;
    reg         rst_i;
    reg  [7:0]  adr_i;
    reg  [31:0] dat_i;
    reg         we_i;
    reg         cyc_i;
    reg         ss_flip;
    reg  [31:0] rd;
    reg  [7:0]  b;
    reg  [7:0]  r;
    wire [31:0] dat_o;
    wire        ack_o, irq_o, int_req_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o;
    wire        miso_o, miso_oe_n_o, ss_gpio_free_o, p_sck, p_dout, p_ss_n;
    integer     n_errors, samples_checked, seed, i, t;
    // Line levels from the port's enables; the peer drives a line the port releases
    wire        sck_w  = sck_oe_n_o ? p_sck : sck_o;
    wire        mosi_w = mosi_oe_n_o ? p_dout : mosi_o;
    wire        miso_w = miso_oe_n_o ? p_dout : miso_o;
    ssp_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(cyc_i), .ack_o(ack_o), .irq_o(irq_o),
        .int_req_o(int_req_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(p_ss_n ^ ss_flip),
        .ss_gpio_free_o(ss_gpio_free_o));
    ssp_peer peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(p_sck),
        .dout_o(p_dout), .ss_n_o(p_ss_n));
    task close_out;
        begin
            if (n_errors == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // Classic cycle; one idle cycle after release lets flags settle
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            t = 0;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && t < 50) begin
                @(posedge clk_i);
                t = t + 1;
            end
            if (t >= 50) n_errors = n_errors + 1;
            rd = dat_o;
            cyc_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0000_0000);
            cmp(rd, e);
        end
    endtask
    // Bounded wait for end of a byte
    task wait_int;
        begin
            t = 0;
            while (int_req_o !== 1'b1 && t < 2000) begin
                @(posedge clk_i);
                t = t + 1;
            end
            if (t >= 2000) n_errors = n_errors + 1;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        n_errors = n_errors + 1;
        close_out;
    end
    initial begin
        seed = 9;
        n_errors = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        dat_i = 32'h0000_0000;
        ss_flip = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(8'h08, 32'h0000_0000);
        rdc(8'h04, 32'h0000_0000);
        rdc(8'h14, 32'h0000_0000);
        wb(1'b1, 8'h10, 32'h0000_000F);
        wb(1'b1, 8'h04, 32'h0000_00D0);
        // Master bytes; a data write while done must be dropped
        for (i = 0; i < 4; i = i + 1) begin
            b = $random(seed);
            r = $random(seed);
            peer.tx_reg = r;
            wb(1'b1, 8'h00, {24'h0, b});
            wait_int;
            cmp(peer.rx_reg, b);
            wb(1'b1, 8'h00, {24'h0, ~b});
            repeat (80) @(posedge clk_i);
            cmp(peer.bits, 8 * i + 8);
            rdc(8'h08, 32'h0000_0080);
            rdc(8'h00, {24'h0, r});
            cmp(int_req_o, 1'b0);
        end
        cmp(irq_o, 1'b1);
        rdc(8'h0C, 32'h0000_0001);
        wb(1'b1, 8'h0C, 32'h0000_000F);
        cmp(irq_o, 1'b0);
        wb(1'b1, 8'h08, 32'h0000_0004);
        cmp(mosi_oe_n_o, 1'b1);
        wb(1'b1, 8'h08, 32'h0000_0000);
        cmp(mosi_oe_n_o, 1'b0);
        // Second write in mid-transfer collides
        b = $random(seed);
        wb(1'b1, 8'h00, {24'h0, b});
        repeat (8) @(posedge clk_i);
        wb(1'b1, 8'h00, 32'h0000_005A);
        wait_int;
        cmp(peer.rx_reg, b);
        rdc(8'h08, 32'h0000_00C0);
        wb(1'b0, 8'h00, 32'h0000_0000);
        rdc(8'h08, 32'h0000_0000);
        rdc(8'h0C, 32'h0000_0003);
        wb(1'b1, 8'h0C, 32'h0000_000F);
        // Select pulled low while master
        ss_flip <= 1'b1;
        repeat (10) @(posedge clk_i);
        ss_flip <= 1'b0;
        cmp(int_req_o, 1'b1);
        rdc(8'h04, 32'h0000_0080);
        wb(1'b1, 8'h04, 32'h0000_0080);
        rdc(8'h08, 32'h0000_0010);
        wb(1'b1, 8'h04, 32'h0000_0080);
        rdc(8'h08, 32'h0000_0000);
        rdc(8'h0C, 32'h0000_0008);
        wb(1'b1, 8'h0C, 32'h0000_000F);
        // Slave: two frames unread give overrun
        wb(1'b1, 8'h04, 32'h0000_00C0);
        b = $random(seed);
        peer.send(b);
        peer.send(~b);
        repeat (10) @(posedge clk_i);
        rdc(8'h08, 32'h0000_00A0);
        rdc(8'h08, 32'h0000_0080);
        rdc(8'h0C, 32'h0000_0005);
        wb(1'b1, 8'h10, 32'h0000_0000);
        cmp(irq_o, 1'b0);
        wb(1'b1, 8'h0C, 32'h0000_000F);
        wb(1'b1, 8'h10, 32'h0000_000F);
        wb(1'b0, 8'h00, 32'h0000_0000);
        // Soft select: deselected despite pin low, then selected with pin high
        wb(1'b1, 8'h08, 32'h0000_0003);
        cmp(ss_gpio_free_o, 1'b1);
        peer.send(8'h3C);
        repeat (10) @(posedge clk_i);
        rdc(8'h08, 32'h0000_0003);
        wb(1'b1, 8'h08, 32'h0000_0002);
        b = $random(seed);
        ss_flip <= 1'b1;
        peer.send(b);
        ss_flip <= 1'b0;
        repeat (10) @(posedge clk_i);
        rdc(8'h08, 32'h0000_0082);
        rdc(8'h00, {24'h0, b});
        close_out;
    end
endmodule
bind ssp_top ssp_top_chk chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_o(dat_o),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o),
    .int_req_o(int_req_o), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .mosi_o(mosi_o),
    .mosi_oe_n_o(mosi_oe_n_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i),
    .ss_gpio_free_o(ss_gpio_free_o));

// ### src/ssp_regs.vh
// Register offsets, field positions and reset values of the serial port
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// Word offsets (byte addresses) on the register bus
`define SSP_DATA_OFF      8'h00
`define SSP_CTRL_OFF      8'h04
`define SSP_CSR_OFF       8'h08
`define SSP_IRQ_STAT_OFF  8'h0C
`define SSP_IRQ_MASK_OFF  8'h10

// Serial control register fields
`define SSP_CR_IE         7
`define SSP_CR_PE         6
`define SSP_CR_MS         4

// Control/status register fields
`define SSP_CSR_DONE      7
`define SSP_CSR_WRITE_COLLISION_FLAG      6
`define SSP_CSR_OVR       5
`define SSP_CSR_MASTER_FAULT_FLAG      4
`define SSP_CSR_SOD       2
`define SSP_CSR_SSM       1
`define SSP_CSR_SSI       0

// Reset values
`define SSP_CSR_RST       8'h00
`define SSP_CR_RST        8'h00

// Serial clock divider: half period in system clocks
`define SSP_HALF_DIV      8'd4

`endif

// ### src/ssp_shifter.v
// Byte shift engine: master drives the clock, slave follows edges
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_shifter (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       master_i,
    input  wire       enable_i,
    input  wire       start_i,
    input  wire [7:0] tx_byte_i,
    input  wire       sck_s_i,
    input  wire       sel_i,
    input  wire       din_i,
    output reg        sck_o,
    output wire       dout_o,
    output reg        busy_o,
    output reg        done_o,
    output reg  [7:0] rx_byte_o
);
    reg [7:0] shift_reg;
    reg [2:0] bit_reg;
    reg [7:0] div_reg;
    reg       sck_prev_reg;
    reg       sample_reg;

    wire tick  = (div_reg == `SSP_HALF_DIV - 8'd1);
    wire s_rise = sck_s_i & ~sck_prev_reg;
    wire s_fall = ~sck_s_i & sck_prev_reg;

    // MSB first, mode 0: sample on rising, shift on falling
    assign dout_o = shift_reg[7];

    always @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg    <= 8'h00;
            bit_reg      <= 3'd0;
            div_reg      <= 8'h00;
            sck_prev_reg <= 1'b0;
            sample_reg   <= 1'b0;
            sck_o        <= 1'b0;
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
            rx_byte_o    <= 8'h00;
        end else begin
            done_o       <= 1'b0;
            sck_prev_reg <= sck_s_i;
            if (!enable_i) begin
                busy_o  <= 1'b0;
                sck_o   <= 1'b0;
                bit_reg <= 3'd0;
            end else if (master_i) begin
                if (start_i && !busy_o) begin
                    shift_reg <= tx_byte_i;
                    busy_o    <= 1'b1;
                    div_reg   <= 8'h00;
                    bit_reg   <= 3'd0;
                end else if (busy_o) begin
                    div_reg <= tick ? 8'h00 : div_reg + 8'd1;
                    if (tick) begin
                        sck_o <= ~sck_o;
                        if (!sck_o) begin
                            sample_reg <= din_i;
                        end else begin
                            shift_reg <= {shift_reg[6:0], sample_reg};
                            bit_reg   <= bit_reg + 3'd1;
                            if (bit_reg == 3'd7) begin
                                busy_o    <= 1'b0;
                                done_o    <= 1'b1;
                                rx_byte_o <= {shift_reg[6:0], sample_reg};
                            end
                        end
                    end
                end
            end else begin
                // Slave: load on write when idle, follow master edges
                if (start_i && !busy_o) begin
                    shift_reg <= tx_byte_i;
                end
                if (!sel_i) begin
                    bit_reg <= 3'd0;
                    busy_o  <= 1'b0;
                end else if (s_rise) begin
                    sample_reg <= din_i;
                    busy_o     <= 1'b1;
                end else if (s_fall) begin
                    shift_reg <= {shift_reg[6:0], sample_reg};
                    bit_reg   <= bit_reg + 3'd1;
                    if (bit_reg == 3'd7) begin
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        rx_byte_o <= {shift_reg[6:0], sample_reg};
                    end
                end
            end
        end
    end
endmodule

// ### src/ssp_sync.v
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module ssp_sync #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage feeds only the second
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule

// ### src/ssp_top.v
// Serial port with status flags, select handling and Wishbone registers
//
// Overview of operation
// - Control/status reads zero after reset
// - Completed byte copied into receive buffer
// - Data read returns buffer, not shifter
// - Master data write starts one byte
// - Data writes ignored while done until read
// - Overrun set when byte completes while done
// - Control/status read clears overrun
// - Master fault on select low as master
// - Fault cleared by status access, control write
// - Fault raises interrupt when enabled
// - Output disable releases data output
// - Soft select mode ignores select pin
// - Soft select level drives internal select
// - Enabled interrupt on done, fault, overrun
// - Fault clears port enable and master
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output reg         ack_o,
    output wire        irq_o,
    output wire        int_req_o,
    input  wire        sck_i,
    output wire        sck_o,
    output wire        sck_oe_n_o,
    input  wire        mosi_i,
    output wire        mosi_o,
    output wire        mosi_oe_n_o,
    input  wire        miso_i,
    output wire        miso_o,
    output wire        miso_oe_n_o,
    input  wire        ss_n_i,
    output wire        ss_gpio_free_o
);
    reg  [7:0] serial_control_reg;
    reg  [7:0] control_status_reg;
    reg  [7:0] rx_buf_reg;
    reg  [7:0] tx_hold_reg;
    reg        start_reg;
    reg        csr_seen_reg;
    reg        master_fault_flag_seen_reg;
    reg  [3:0] irq_stat_reg;
    reg  [3:0] irq_mask_reg;

    wire [2:0] pins_s;
    wire       sck_s;
    wire       ss_pin_n_s;
    wire       miso_s;
    wire       mosi_s;
    wire       sh_sck;
    wire       sh_dout;
    wire       sh_busy;
    wire       sh_done;
    wire [7:0] sh_rx;

    // Field views
    wire ie      = serial_control_reg[`SSP_CR_IE];
    wire pe      = serial_control_reg[`SSP_CR_PE];
    wire master  = serial_control_reg[`SSP_CR_MS];
    wire done_f  = control_status_reg[`SSP_CSR_DONE];
    wire write_collision_flag_f  = control_status_reg[`SSP_CSR_WRITE_COLLISION_FLAG];
    wire ovr_f   = control_status_reg[`SSP_CSR_OVR];
    wire master_fault_flag_f  = control_status_reg[`SSP_CSR_MASTER_FAULT_FLAG];
    wire output_disable     = control_status_reg[`SSP_CSR_SOD];
    wire soft_select_mode     = control_status_reg[`SSP_CSR_SSM];
    wire soft_select_level     = control_status_reg[`SSP_CSR_SSI];

    // Address match; one place to change if the map moves
    function hit_at;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit_at = (adr == off);
        end
    endfunction

    // Pins from the link are synchronised before use
    ssp_sync #(
        .W(3)
    ) u_sync_pins (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({sck_i, miso_i, mosi_i}),
        .q_o   (pins_s)
    );

    // Select pin synchronised; resets high so no false fault
    reg ss_m_reg;
    reg ss_s_reg;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ss_m_reg <= 1'b1;
            ss_s_reg <= 1'b1;
        end else begin
            ss_m_reg <= ss_n_i;
            ss_s_reg <= ss_m_reg;
        end
    end
    assign ss_pin_n_s = ss_s_reg;
    assign sck_s  = pins_s[2];
    assign miso_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // Internal select: software level or pin
    wire ss_int_n = soft_select_mode ? soft_select_level : ss_pin_n_s;
    assign ss_gpio_free_o = soft_select_mode | ~pe;

    // Fault: select asserted while master and enabled
    wire fault_evt = master & ~ss_int_n;

    // Bus decode
    wire        acc     = cyc_i & stb_i & ~ack_o;
    wire        wr      = acc & we_i & sel_i[0];
    wire        rd      = acc & ~we_i;
    wire        hit_dat = hit_at(adr_i, `SSP_DATA_OFF);
    wire        hit_cr  = hit_at(adr_i, `SSP_CTRL_OFF);
    wire        hit_csr = hit_at(adr_i, `SSP_CSR_OFF);
    wire        hit_ist = hit_at(adr_i, `SSP_IRQ_STAT_OFF);
    wire        hit_imk = hit_at(adr_i, `SSP_IRQ_MASK_OFF);

    // Per-register strobes
    wire        csr_acc = acc & hit_csr;
    wire        dat_acc = acc & hit_dat;
    wire        dat_wr  = wr & hit_dat;
    wire        cr_wr   = wr & hit_cr;

    // Data write accepted unless done flag pending without status read
    wire dat_wr_ok = dat_wr & ~(done_f & ~csr_seen_reg);
    wire write_collision_flag_evt  = dat_wr & sh_busy;
    wire start_ok  = dat_wr_ok & ~sh_busy & pe;
    wire ovr_evt   = sh_done & done_f;
    wire seq_clear = dat_acc & csr_seen_reg;

    // Receive line follows the role: slave out as master, master out as slave
    wire din_s = master ? miso_s : mosi_s;

    // Shift engine
    ssp_shifter u_shift (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .master_i  (master),
        .enable_i  (pe),
        .start_i   (start_reg),
        .tx_byte_i (tx_hold_reg),
        .sck_s_i   (sck_s),
        .sel_i     (~ss_int_n),
        .din_i     (din_s),
        .sck_o     (sh_sck),
        .dout_o    (sh_dout),
        .busy_o    (sh_busy),
        .done_o    (sh_done),
        .rx_byte_o (sh_rx)
    );

    // Start pulse and transmit byte latched on an accepted write
    // Only an accepted write reaches the engine; a dropped byte is lost
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_reg   <= 1'b0;
            tx_hold_reg <= 8'h00;
        end else begin
            start_reg <= start_ok;
            if (start_ok) begin
                tx_hold_reg <= dat_i[7:0];
            end
        end
    end

    // Receive buffer, loaded only at byte end
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_buf_reg <= 8'h00;
        end else if (sh_done) begin
            rx_buf_reg <= sh_rx;
        end
    end

    // Status read arms the done and collision clear; a data access uses it
    always @(posedge clk_i) begin
        if (rst_i) begin
            csr_seen_reg <= 1'b0;
        end else if (csr_acc && rd) begin
            csr_seen_reg <= 1'b1;
        end else if (dat_acc) begin
            csr_seen_reg <= 1'b0;
        end
    end

    // Fault clear armed by any status access while the fault stands;
    // a status write counts too, since the flag bits cannot be written
    always @(posedge clk_i) begin
        if (rst_i) begin
            master_fault_flag_seen_reg <= 1'b0;
        end else if (csr_acc && master_fault_flag_f) begin
            master_fault_flag_seen_reg <= 1'b1;
        end else if (cr_wr) begin
            master_fault_flag_seen_reg <= 1'b0;
        end
    end

    // Control register; fault forces port and master off
    always @(posedge clk_i) begin
        if (rst_i) begin
            serial_control_reg <= `SSP_CR_RST;
        end else begin
            if (cr_wr) begin
                serial_control_reg <= dat_i[7:0];
            end
            if (fault_evt && pe) begin
                serial_control_reg[`SSP_CR_PE] <= 1'b0;
                serial_control_reg[`SSP_CR_MS] <= 1'b0;
            end
        end
    end

    // Status flags: events win over clears in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            control_status_reg <= `SSP_CSR_RST;
        end else begin
            if (wr && hit_csr) begin
                control_status_reg[2:0] <= dat_i[2:0];
                control_status_reg[3]   <= 1'b0;
            end
            // Software clears first
            if (seq_clear) begin
                control_status_reg[`SSP_CSR_DONE] <= 1'b0;
                control_status_reg[`SSP_CSR_WRITE_COLLISION_FLAG] <= 1'b0;
            end
            if (csr_acc && rd) begin
                control_status_reg[`SSP_CSR_OVR] <= 1'b0;
            end
            if (cr_wr && master_fault_flag_seen_reg) begin
                control_status_reg[`SSP_CSR_MASTER_FAULT_FLAG] <= 1'b0;
            end
            // Events last, so a set outweighs a clear in the same cycle
            if (sh_done) begin
                control_status_reg[`SSP_CSR_DONE] <= 1'b1;
            end
            if (write_collision_flag_evt) begin
                control_status_reg[`SSP_CSR_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (ovr_evt) begin
                control_status_reg[`SSP_CSR_OVR] <= 1'b1;
            end
            if (fault_evt && pe) begin
                control_status_reg[`SSP_CSR_MASTER_FAULT_FLAG] <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    wire [3:0] evts;
    wire       ist_wr = wr & hit_ist;
    wire [3:0] irq_stat_next;
    genvar     gi;
    assign evts[0] = sh_done;
    assign evts[1] = write_collision_flag_evt;
    assign evts[2] = ovr_evt;
    assign evts[3] = fault_evt & pe;

    // Per bit: a new event outweighs a clear in the same cycle
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sticky
            assign irq_stat_next[gi] = evts[gi] | (irq_stat_reg[gi] & ~(ist_wr & dat_i[gi]));
        end
    endgenerate

    // Status and mask registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr && hit_imk) begin
                irq_mask_reg <= dat_i[3:0];
            end
        end
    end
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // Shared request from the flags themselves
    assign int_req_o = ie & (done_f | master_fault_flag_f | ovr_f);

    // Read word chosen combinationally, registered with the ack
    reg [31:0] dat_next;
    always @* begin
        case (adr_i)
            `SSP_DATA_OFF:     dat_next = {24'h00_0000, rx_buf_reg};
            `SSP_CTRL_OFF:     dat_next = {24'h00_0000, serial_control_reg};
            `SSP_CSR_OFF:      dat_next = {24'h00_0000, control_status_reg};
            `SSP_IRQ_STAT_OFF: dat_next = {28'h000_0000, irq_stat_reg};
            `SSP_IRQ_MASK_OFF: dat_next = {28'h000_0000, irq_mask_reg};
            default:           dat_next = 32'h0000_0000;
        endcase
    end

    // Bus answer: one wait-free ack, zero for unmapped
    // Writes leave dat_o alone; it holds until the next read
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= acc;
            if (rd) begin
                dat_o <= dat_next;
            end
        end
    end

    // Pin drive; enables are active low
    wire out_en = pe & ~output_disable;

    // Clock pin driven only in the master role
    assign sck_o       = sh_sck;
    assign sck_oe_n_o  = ~(pe & master);

    // Data out follows the role; a deselected slave lets its line go,
    // so that several slaves may share it
    assign mosi_o      = sh_dout;
    assign mosi_oe_n_o = ~(out_en & master);
    assign miso_o      = sh_dout;
    assign miso_oe_n_o = ~(out_en & ~master & ~ss_int_n);
endmodule
